// >>> core/seq_core.sv
// Machine cycle and state sequencer with an AXI4-Lite control port.
// Assumes two slow nonoverlapping clock phases and ready arrive as pins.
//
// The register addresses and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps

module seq_core
  import seq_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        phase1,
  input  wire logic        phase2,
  input  wire logic        ready,
  input  wire logic [7:0]  data_in,
  output logic [7:0]       data_out,
  output logic             data_oe,
  output logic             cycle_start,
  output logic             wait_state,
  output logic             addr_load,
  output logic             instr_done
);

  // Pin synchronisers
  logic [10:0] pin_m;
  logic [10:0] pin_s;
  logic        p1_d;
  logic        p2_d;
  logic        p1_rise;
  logic        p2_rise;
  logic        ready_s;
  logic [7:0]  din_s;

  always_ff @(posedge aclk)
  begin
    pin_m <= {data_in, ready, phase2, phase1};
    pin_s <= pin_m;
    p1_d  <= pin_s[0];
    p2_d  <= pin_s[1];
  end

  assign p1_rise = pin_s[0] && !p1_d;
  assign p2_rise = pin_s[1] && !p2_d;
  assign ready_s = pin_s[2];
  assign din_s   = pin_s[10:3];

  // Sequencer
  seq_state_e  st;
  seq_state_e  next_st;
  logic [2:0]  mc_idx;
  logic [2:0]  next_mc_idx;
  logic [3:0]  cls;
  logic [3:0]  next_cls;
  logic        wait_req;
  logic        next_wait_req;
  logic [7:0]  last_data;
  logic [7:0]  next_last_data;
  logic [15:0] instr_cnt;
  logic [15:0] next_instr_cnt;
  logic [7:0]  next_data_out;
  logic        next_data_oe;
  logic        next_cycle_start;
  logic        next_addr_load;
  logic        next_instr_done;
  seq_ctrl_s   ctrl;
  seq_cyc_s    cur;
  logic        end_mc;

  assign cur = seq_script(cls, mc_idx);

  always_comb
  begin
    next_st          = st;
    next_mc_idx      = mc_idx;
    next_cls         = cls;
    next_wait_req    = wait_req;
    next_last_data   = last_data;
    next_instr_cnt   = instr_cnt;
    next_data_out    = data_out;
    next_data_oe     = data_oe;
    next_cycle_start = cycle_start;
    next_addr_load   = 1'b0;
    next_instr_done  = 1'b0;
    end_mc           = 1'b0;
    if (p2_rise)
    begin
      if (st == S_T1 && cur.kind != K_INTERNAL)
      begin
        next_cycle_start = 1'b1;
        next_data_oe     = 1'b1;
        next_data_out    = seq_status(cur.kind);
        next_addr_load   = 1'b1;
      end
      if (st == S_T2 || st == S_TW)
      begin
        next_cycle_start = 1'b0;
        next_data_oe     = 1'b0;
        next_wait_req    = !ready_s;
      end
      if (st == S_T3)
        next_last_data = din_s;
    end
    if (p1_rise)
    begin
      unique case (st)
        S_IDLE:
          if (ctrl.run)
          begin
            next_cls    = ctrl.cls;
            next_mc_idx = '0;
            next_st     = S_T1;
          end
        S_T1: next_st = S_T2;
        S_T2:
          if (cur.kind == K_HALT)
            next_st = S_HALT;
          else if (wait_req && cur.kind != K_INTERNAL)
            next_st = S_TW;
          else
            next_st = S_T3;
        S_TW:
          if (!wait_req)
            next_st = S_T3;
        S_T3:
          if (cur.states > SEQ_ST3)
            next_st = S_T4;
          else
            end_mc = 1'b1;
        S_T4:
          if (cur.states > SEQ_ST4)
            next_st = S_T5;
          else
            end_mc = 1'b1;
        S_T5: end_mc = 1'b1;
        S_HALT:
          if (!ctrl.run)
            end_mc = 1'b1;
      endcase
    end
    if (end_mc)
    begin
      next_wait_req = 1'b0;
      if (mc_idx == seq_length(cls) - 3'h1)
      begin
        next_instr_done = 1'b1;
        next_instr_cnt  = instr_cnt + 16'h0001;
        next_mc_idx     = '0;
        next_cls        = ctrl.cls;
        next_st         = ctrl.run ? S_T1 : S_IDLE;
      end
      else
      begin
        next_mc_idx = mc_idx + 3'h1;
        next_st     = S_T1;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st          <= S_IDLE;
      mc_idx      <= '0;
      cls         <= C_ADD_REG;
      wait_req    <= 1'b0;
      last_data   <= '0;
      instr_cnt   <= '0;
      data_out    <= '0;
      data_oe     <= 1'b0;
      cycle_start <= 1'b0;
      wait_state  <= 1'b0;
      addr_load   <= 1'b0;
      instr_done  <= 1'b0;
    end
    else
    begin
      st          <= next_st;
      mc_idx      <= next_mc_idx;
      cls         <= next_cls;
      wait_req    <= next_wait_req;
      last_data   <= next_last_data;
      instr_cnt   <= next_instr_cnt;
      data_out    <= next_data_out;
      data_oe     <= next_data_oe;
      cycle_start <= next_cycle_start;
      wait_state  <= (next_st == S_TW);
      addr_load   <= next_addr_load;
      instr_done  <= next_instr_done;
    end
  end

  // AXI4-Lite slave
  logic        aw_full;
  logic        next_aw_full;
  logic        w_full;
  logic        next_w_full;
  logic [11:0] aw_addr;
  logic [11:0] next_aw_addr;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic        w_lane0;
  logic        next_w_lane0;
  seq_ctrl_s   next_ctrl;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_arready;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  seq_stat_s   stat;

  assign stat = '{8'h00, last_data, cur.kind, {1'b0, mc_idx}, st};

  always_comb
  begin
    next_aw_full = aw_full || (awvalid && awready);
    next_w_full  = w_full || (wvalid && wready);
    next_aw_addr = (awvalid && awready) ? awaddr : aw_addr;
    next_w_data  = (wvalid && wready) ? wdata : w_data;
    next_w_lane0 = (wvalid && wready) ? wstrb[0] : w_lane0;
    next_ctrl    = ctrl;
    next_bvalid  = bvalid && !bready;
    next_bresp   = bresp;
    next_arready = arready;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (aw_full && w_full && !bvalid)
    begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (aw_addr == SEQ_A_CTRL) ? AXI_OKAY : AXI_SLVERR;
      if (aw_addr == SEQ_A_CTRL && w_lane0)
      begin
        next_ctrl     = seq_ctrl_s'(w_data);
        next_ctrl.rsv_hi = '0;
        next_ctrl.rsv_lo = '0;
      end
    end
    if (arvalid && arready)
    begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rresp   = AXI_OKAY;
      unique case (araddr)
        SEQ_A_CTRL:  next_rdata = ctrl;
        SEQ_A_STAT:  next_rdata = stat;
        SEQ_A_COUNT: next_rdata = {16'h0000, instr_cnt};
        default:
        begin
          next_rdata = '0;
          next_rresp = AXI_SLVERR;
        end
      endcase
    end
    else if (rvalid && rready)
    begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= '0;
      w_data  <= '0;
      w_lane0 <= 1'b0;
      ctrl    <= '0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= AXI_OKAY;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= AXI_OKAY;
    end
    else
    begin
      aw_full <= next_aw_full;
      w_full  <= next_w_full;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_lane0 <= next_w_lane0;
      ctrl    <= next_ctrl;
      awready <= !next_aw_full && !next_bvalid;
      wready  <= !next_w_full && !next_bvalid;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      arready <= next_arready || (!next_rvalid && !arready && !rvalid);
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  // Checks; helper counts non-wait states of an instruction
  logic [4:0] inst_states;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || instr_done)
      inst_states <= '0;
    else if (p1_rise && (st inside {S_T1, S_T2, S_T3, S_T4, S_T5}))
      inst_states <= inst_states + 5'h01;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_mcyc_bound: assert property (
    mc_idx < seq_length(cls)) else $error("machine cycle index past end");
  a_inst_states: assert property (
    $rose(instr_done) |-> inst_states >= SEQ_MIN_INSTR_ST && inst_states <= SEQ_MAX_INSTR_ST)
    else $error("instruction state count out of range");
  a_sync_phi2: assert property (
    $rose(cycle_start) |-> $past(p2_rise) && $past(st) == S_T1) else $error("strobe not on phase two");
  a_pair_quiet: assert property (
    cur.kind == K_INTERNAL |-> !cycle_start && !addr_load) else $error("strobe in internal cycle");
  a_status_window: assert property (
    data_oe |-> cycle_start && (st inside {S_T1, S_T2})) else $error("status outside strobe");
  a_fetch_bit: assert property (
    $rose(data_oe) |-> data_out[SEQ_BIT_FETCH] == (mc_idx == 3'h0))
    else $error("fetch bit wrong");
  a_stack_read: assert property (
    $rose(data_oe) && cur.kind == K_SREAD |-> data_out[SEQ_BIT_STACK] && data_out[SEQ_BIT_MEMORY_READ_FLAG])
    else $error("stack read status wrong");
  a_first_fetch: assert property (
    $rose(data_oe) && mc_idx == 3'h0 |-> data_out[SEQ_BIT_FETCH]) else $error("no opening fetch");
  a_wait_hold: assert property (
    st == S_TW && wait_req && p1_rise |=> st == S_TW && wait_state) else $error("left wait early");
  a_wait_edge: assert property (
    $rose(wait_state) |-> $past(p1_rise) && $past(st) == S_T2) else $error("wait not on phase one");

endmodule

// >>> pkg/seq_pkg.sv
// Constants, types and cycle scripts of the machine cycle sequencer.
// Assumes a single 50 MHz clock and AXI4-Lite register access.
package seq_pkg;

  // Sequencer states, one-hot
  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_T1   = 8'h02,
    S_T2   = 8'h04,
    S_TW   = 8'h08,
    S_T3   = 8'h10,
    S_T4   = 8'h20,
    S_T5   = 8'h40,
    S_HALT = 8'h80
  } seq_state_e;

  // Machine cycle kinds
  typedef enum logic [3:0] {
    K_FETCH    = 4'h0,
    K_MREAD    = 4'h1,
    K_MWRITE   = 4'h2,
    K_SREAD    = 4'h3,
    K_SWRITE   = 4'h4,
    K_INPUT    = 4'h5,
    K_OUTPUT   = 4'h6,
    K_INTERRUPT_ACKNOWLEDGE_FLAG     = 4'h7,
    K_HALT     = 4'h8,
    K_HALTINT  = 4'h9,
    K_INTERNAL = 4'ha
  } seq_kind_e;

  typedef struct packed {
    seq_kind_e  kind;
    logic [2:0] states;
  } seq_cyc_s;

  typedef struct packed {
    logic [23:0] rsv_hi;
    logic [3:0]  cls;
    logic [2:0]  rsv_lo;
    logic        run;
  } seq_ctrl_s;

  typedef struct packed {
    logic [7:0] rsv;
    logic [7:0] last_data;
    seq_kind_e  kind;
    logic [3:0] mc_idx;
    seq_state_e state;
  } seq_stat_s;

  // Status word bits on the data lines
  localparam int SEQ_BIT_INTERRUPT_ACKNOWLEDGE_FLAG  = 0;
  localparam int SEQ_BIT_WO_N  = 1;
  localparam int SEQ_BIT_STACK = 2;
  localparam int SEQ_BIT_HALT_ACKNOWLEDGE_FLAG  = 3;
  localparam int SEQ_BIT_OUT   = 4;
  localparam int SEQ_BIT_FETCH = 5;
  localparam int SEQ_BIT_INP   = 6;
  localparam int SEQ_BIT_MEMORY_READ_FLAG  = 7;

  // Instruction classes
  localparam logic [3:0] C_ADD_REG  = 4'h0;
  localparam logic [3:0] C_ADD_MEM  = 4'h1;
  localparam logic [3:0] C_PAIR_ADD = 4'h2;
  localparam logic [3:0] C_STORE_HL = 4'h3;
  localparam logic [3:0] C_PORT_IN  = 4'h4;
  localparam logic [3:0] C_PORT_OUT = 4'h5;
  localparam logic [3:0] C_PUSH     = 4'h6;
  localparam logic [3:0] C_POP      = 4'h7;
  localparam logic [3:0] C_HALT     = 4'h8;
  localparam logic [3:0] C_INT_RST  = 4'h9;

  localparam logic [2:0] SEQ_ST3 = 3'h3;
  localparam logic [2:0] SEQ_ST4 = 3'h4;
  localparam logic [2:0] SEQ_ST5 = 3'h5;
  localparam logic [4:0] SEQ_MIN_INSTR_ST = 5'h04;
  localparam logic [4:0] SEQ_MAX_INSTR_ST = 5'h12;

  // AXI4-Lite map
  localparam logic [11:0] SEQ_A_CTRL  = 12'h000;
  localparam logic [11:0] SEQ_A_STAT  = 12'h004;
  localparam logic [11:0] SEQ_A_COUNT = 12'h008;
  localparam logic [1:0]  AXI_OKAY    = 2'h0;
  localparam logic [1:0]  AXI_SLVERR  = 2'h2;

  function automatic logic [2:0] seq_length(input logic [3:0] cls);
    unique case (cls)
      C_ADD_MEM, C_HALT: seq_length = 3'h2;
      C_STORE_HL: seq_length = 3'h5;
      C_PAIR_ADD, C_PORT_IN, C_PORT_OUT, C_PUSH, C_POP, C_INT_RST: seq_length = 3'h3;
      default:    seq_length = 3'h1;
    endcase
  endfunction

  function automatic seq_cyc_s seq_script(input logic [3:0] cls, input logic [2:0] idx);
    seq_script = '{K_FETCH, SEQ_ST4};
    if (idx != 3'h0)
    begin
      unique case (cls)
        C_ADD_MEM:  seq_script = '{K_MREAD, SEQ_ST3};
        C_PAIR_ADD: seq_script = '{K_INTERNAL, SEQ_ST3};
        C_STORE_HL: seq_script = (idx < 3'h3) ? seq_cyc_s'{K_MREAD, SEQ_ST3}
                                              : seq_cyc_s'{K_MWRITE, SEQ_ST3};
        C_PORT_IN:  seq_script = (idx == 3'h1) ? seq_cyc_s'{K_MREAD, SEQ_ST3}
                                               : seq_cyc_s'{K_INPUT, SEQ_ST3};
        C_PORT_OUT: seq_script = (idx == 3'h1) ? seq_cyc_s'{K_MREAD, SEQ_ST3}
                                               : seq_cyc_s'{K_OUTPUT, SEQ_ST3};
        C_PUSH, C_INT_RST: seq_script = '{K_SWRITE, SEQ_ST3};
        C_POP:      seq_script = '{K_SREAD, SEQ_ST3};
        C_HALT:     seq_script = '{K_HALT, SEQ_ST3};
        default:    seq_script = '{K_FETCH, SEQ_ST4};
      endcase
    end
    else if (cls == C_PUSH)
      seq_script = '{K_FETCH, SEQ_ST5};
    else if (cls == C_INT_RST)
      seq_script = '{K_INTERRUPT_ACKNOWLEDGE_FLAG, SEQ_ST5};
  endfunction

  function automatic logic [7:0] seq_status(input seq_kind_e kind);
    logic [7:0] s;
    s = '0;
    s[SEQ_BIT_WO_N]  = !(kind inside {K_MWRITE, K_SWRITE, K_OUTPUT});
    s[SEQ_BIT_STACK] = kind inside {K_SREAD, K_SWRITE};
    s[SEQ_BIT_HALT_ACKNOWLEDGE_FLAG]  = kind inside {K_HALT, K_HALTINT};
    s[SEQ_BIT_OUT]   = kind == K_OUTPUT;
    s[SEQ_BIT_FETCH] = kind inside {K_FETCH, K_INTERRUPT_ACKNOWLEDGE_FLAG, K_HALTINT};
    s[SEQ_BIT_INP]   = kind == K_INPUT;
    s[SEQ_BIT_MEMORY_READ_FLAG]  = kind inside {K_FETCH, K_MREAD, K_SREAD, K_HALT};
    s[SEQ_BIT_INTERRUPT_ACKNOWLEDGE_FLAG]  = kind inside {K_INTERRUPT_ACKNOWLEDGE_FLAG, K_HALTINT};
    seq_status = s;
  endfunction

endpackage

// >>> verification/seq_far_model.sv
// Far-side model: two-phase clock source, memory ready and status latch.
// Assumes the bench supplies aclk, aresetn and a stall request.
`timescale 1ns/100ps
module seq_far_model
  import seq_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       stall,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  output logic            phase1,
  output logic            phase2,
  output logic            ready,
  output logic [7:0]      data_in,
  output logic [7:0]      status_latch
);
  logic [3:0] ph_cnt;
  logic [7:0] pat;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ph_cnt       <= 4'h0;
      pat          <= 8'h00;
      status_latch <= 8'h00;
    end
    else
    begin
      ph_cnt <= ph_cnt + 4'h1;
      pat    <= pat + 8'h3b;
      if (data_oe)
        status_latch <= data_out;
    end
  end

  // Nonoverlapping phases, each high four aclk in sixteen
  assign phase1  = ph_cnt < 4'h4;
  assign phase2  = (ph_cnt >= 4'h7) && (ph_cnt < 4'hb);
  assign ready   = !stall;
  // Undriven data lines change every cycle
  assign data_in = pat;
endmodule

// >>> verification/cpu_machine_cycle_sequencer_tb_top.sv
// Testbench of the machine cycle sequencer.
// Assumes seq_core and seq_far_model; registers over AXI4-Lite.
`timescale 1ns/100ps
module cpu_machine_cycle_sequencer_tb_top
  import seq_pkg::*;
;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, stall;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, phase1, phase2, ready;
  logic        data_oe, cycle_start, wait_state, addr_load, instr_done, p1_q, cs_q;
  logic [7:0]  data_in, data_out, status_latch;
  logic [39:0] stat_acc, got_stat;
  int          n_errors, n_tests, ticks, nstr, nadr, nwt, n_done;
  int          got_states, got_str, got_adr, got_wt;

  seq_core i_seq_core (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .phase1(phase1), .phase2(phase2), .ready(ready), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .cycle_start(cycle_start),
    .wait_state(wait_state), .addr_load(addr_load), .instr_done(instr_done));

  seq_far_model i_seq_far_model (.aclk(aclk), .aresetn(aresetn), .stall(stall),
    .data_out(data_out), .data_oe(data_oe), .phase1(phase1), .phase2(phase2),
    .ready(ready), .data_in(data_in), .status_latch(status_latch));

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // Per-instruction tally of states, strobes, status words and waits
  always @(posedge aclk)
  begin
    p1_q <= phase1;
    cs_q <= cycle_start;
    if (phase1 && !p1_q)
    begin
      ticks <= ticks + 1;
      if (wait_state)
        nwt <= nwt + 1;
    end
    if (cycle_start && !cs_q)
    begin
      stat_acc <= {stat_acc[31:0], data_out};
      nstr     <= nstr + 1;
    end
    if (addr_load)
      nadr <= nadr + 1;
    if (instr_done)
    begin
      got_states <= ticks;
      got_stat   <= stat_acc;
      got_str    <= nstr;
      got_adr    <= nadr;
      got_wt     <= nwt;
      ticks      <= 0;
      stat_acc   <= '0;
      nstr       <= 0;
      nadr       <= 0;
      nwt        <= 0;
      n_done     <= n_done + 1;
    end
  end

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    int   i;
    logic aw_ok, w_ok, b_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 50 && !(aw_ok && w_ok); i++)
    begin
      @(posedge aclk);
      if (!aw_ok && awready)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    for (i = 0; i < 50 && !b_ok; i++)
    begin
      @(posedge aclk);
      b_ok = bvalid;
      r = bresp;
    end
    bready <= 1'b0;
    if (!b_ok)
    begin
      n_errors++;
      complete_run;
    end
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    int   i;
    logic ar_ok, r_ok;
    ar_ok = 1'b0;
    r_ok = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 50 && !ar_ok; i++)
    begin
      @(posedge aclk);
      ar_ok = arready;
    end
    arvalid <= 1'b0;
    rready <= 1'b1;
    for (i = 0; i < 50 && !r_ok; i++)
    begin
      @(posedge aclk);
      r_ok = rvalid;
      d = rdata;
      r = rresp;
    end
    rready <= 1'b0;
    if (!r_ok)
    begin
      n_errors++;
      complete_run;
    end
  endtask

  task automatic wait_done(input int n);
    int i, t;
    t = n_done + n;
    for (i = 0; i < 6000 && n_done < t; i++)
      @(posedge aclk);
    if (n_done < t)
    begin
      n_errors++;
      complete_run;
    end
  endtask

  task automatic scen_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(SEQ_A_CTRL, d, r);
    check({r, d}, {AXI_OKAY, 32'h0});
    axi_read(SEQ_A_STAT, d, r);
    check(d[7:0], 8'h01);
    axi_read(12'h00c, d, r);
    check({r, d}, {AXI_SLVERR, 32'h0});
    axi_write(SEQ_A_STAT, 32'h0000_0001, r);
    check(r, AXI_SLVERR);
  endtask

  // One class, run held on; the second completed instruction is judged
  task automatic run_class(input logic [3:0] cls, input int st, input int ns,
                           input logic [39:0] stat);
    logic [1:0] r;
    axi_write(SEQ_A_CTRL, {24'h0, cls, 4'h1}, r);
    check(r, AXI_OKAY);
    wait_done(2);
    check(got_states, st);
    check(got_str, ns);
    check(got_adr, ns);
    check(got_stat, stat);
    check(status_latch, stat[7:0]);
  endtask

  task automatic scen_wait;
    int i;
    wait_done(1);
    stall <= 1'b1;
    for (i = 0; i < 400 && wait_state !== 1'b1; i++)
      @(posedge aclk);
    if (wait_state !== 1'b1)
    begin
      n_errors++;
      complete_run;
    end
    repeat (48) @(posedge aclk);
    stall <= 1'b0;
    wait_done(1);
    check(got_wt > 0, 1'b1);
    check(got_states, 7 + got_wt);
    check(got_stat, 40'ha282);
  endtask

  task automatic scen_halt;
    logic [1:0]  r;
    logic [31:0] v;
    int          i, d0;
    axi_write(SEQ_A_CTRL, {24'h0, C_HALT, 4'h1}, r);
    for (i = 0; i < 2000 && status_latch !== 8'h8a; i++)
      @(posedge aclk);
    if (status_latch !== 8'h8a)
    begin
      n_errors++;
      complete_run;
    end
    d0 = n_done;
    repeat (300) @(posedge aclk);
    check(n_done, d0);
    axi_write(SEQ_A_CTRL, 32'h0, r);
    wait_done(1);
    check(got_stat, 40'ha28a);
    axi_read(SEQ_A_COUNT, v, r);
    check({r, v}, {AXI_OKAY, n_done});
    axi_read(SEQ_A_STAT, v, r);
    check(v[15:0], 16'h0001);
  endtask

  initial
  begin
    aresetn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    stall = 1'b0;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'h0;
    stat_acc = '0;
    {n_errors, n_tests, ticks, nstr, nadr, nwt, n_done} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    scen_regs;
    run_class(C_ADD_REG, 4, 1, 40'ha2);
    run_class(C_ADD_MEM, 7, 2, 40'ha282);
    run_class(C_PAIR_ADD, 10, 1, 40'ha2);
    run_class(C_STORE_HL, 16, 5, 40'ha2_8282_0000);
    run_class(C_PORT_IN, 10, 3, 40'ha28242);
    run_class(C_PORT_OUT, 10, 3, 40'ha28210);
    run_class(C_PUSH, 11, 3, 40'ha20404);
    run_class(C_POP, 10, 3, 40'ha28686);
    run_class(C_INT_RST, 11, 3, 40'h230404);
    run_class(4'ha, 4, 1, 40'ha2);
    run_class(C_ADD_MEM, 7, 2, 40'ha282);
    scen_wait;
    scen_halt;
    complete_run;
  end
endmodule
